//--- logic/serial_config_write_port.v
// Serial configuration write port: frame receiver, register file, mode select
`timescale 1ns/1ps
`include "serial_config_defs.vh"
module serial_config_write_port #(
   parameter EXT_MODE_LEVEL = 1'b1
) (
   input  wire        clk_sys,
   input  wire        srst,
   input  wire        serialClock,
   input  wire        serialInputLine,
   input  wire        serialSelectN,
   input  wire        rangeOrModeSelectPin,
   input  wire        edgeSelectPin,
   input  wire        swingSelectPin,
   input  wire        singleRateOutput,
   output reg         extendedMode,
   output reg         accessActive,
   output reg         commitPulse,
   output reg         headerError,
   output reg  [3:0]  commitAddr,
   output reg         diffResetInputSel,
   output reg         terminationTrimOff,
   output reg         dutyStabilizerOn,
   output reg         doubleRateClockPhase,
   output reg         singleRateSelect,
   output reg         outputSwingSelect,
   output reg         outputEdgeSelect,
   output reg  [15:0] inputOffsetAdjust,
   output reg  [15:0] fullScaleGainAdjust,
   output reg  [15:0] sampleClockPhaseFine,
   output reg  [15:0] sampleClockPhaseCoarse,
   output reg  [15:0] testPatternControl
);

   // -------------------------------------------------------------------------
   // Input synchronisation
   // -------------------------------------------------------------------------
   // Order: clock, data, select, mode, edge pin, swing pin, rate pin
   wire [6:0] pinsSync;

   sync_two_stage #(
      .WIDTH     (7),
      .RESET_VAL (7'h10)
   ) u_sync (
      .clk_sys (clk_sys),
      .srst    (srst),
      .asyncIn ({serialClock, serialInputLine, serialSelectN, rangeOrModeSelectPin,
                 edgeSelectPin, swingSelectPin, singleRateOutput}),
      .syncOut (pinsSync)
   );

   wire sclkSync   = pinsSync[6];
   wire dataSync   = pinsSync[5];
   wire selNSync   = pinsSync[4];
   wire modeSync   = pinsSync[3];
   wire edgePinS   = pinsSync[2];
   wire swingPinS  = pinsSync[1];
   wire ratePinS   = pinsSync[0];

   // -------------------------------------------------------------------------
   // Control mode
   // -------------------------------------------------------------------------
   // Mode pin is a static strap; it is followed but not expected to move
   wire extNow = (modeSync == EXT_MODE_LEVEL);

   // -------------------------------------------------------------------------
   // Serial clock edge detection
   // -------------------------------------------------------------------------
   reg  sclkPrev_q;
   reg  selNPrev_q;

   always @(posedge clk_sys) begin
      if (srst) begin
         sclkPrev_q <= 1'b0;
         selNPrev_q <= 1'b1;
      end else begin
         sclkPrev_q <= sclkSync;
         selNPrev_q <= selNSync;
      end
   end

   // Edge detection uses only sampled levels, so any slow serial clock works
   wire sclkRise = sclkSync & ~sclkPrev_q;
   wire selRise  = selNSync & ~selNPrev_q;
   wire portOpen = extNow & ~selNSync;
   wire bitTake  = portOpen & sclkRise;

   // -------------------------------------------------------------------------
   // Frame receiver
   // -------------------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_SHIFT = 3'b010;
   localparam [2:0] ST_DONE  = 3'b100;

   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg  [4:0]  bitCnt_q;
   reg  [4:0]  bitCnt_d;
   reg  [30:0] shift_q;
   reg  [30:0] shift_d;

   // Full frame as it stands once the 32nd bit arrives, MSB first
   wire [31:0] frameFull = {shift_q, dataSync};
   wire        headerOk  = (frameFull[`SCP_HEADER_MSB:`SCP_HEADER_LSB]
                            == `SCP_HEADER_VALUE);
   wire [3:0]  frameAddr = frameFull[`SCP_ADDR_MSB:`SCP_ADDR_LSB];
   wire [15:0] frameData = frameFull[`SCP_DATA_MSB:`SCP_DATA_LSB];
   wire        lastBit   = (bitCnt_q == 5'h1f);
   // Reserved addresses complete silently: no commit, no fault
   wire        addrKnown = (frameAddr == `SCP_ADDR_CONFIG)     |
                           (frameAddr == `SCP_ADDR_OFFSET)     |
                           (frameAddr == `SCP_ADDR_FULLSCALE)  |
                           (frameAddr == `SCP_ADDR_PHASE_FINE) |
                           (frameAddr == `SCP_ADDR_PHASE_CRS)  |
                           (frameAddr == `SCP_ADDR_TEST_PAT);
   wire        commitNow = bitTake & lastBit & headerOk & addrKnown;
   wire        badFrame  = bitTake & lastBit & ~headerOk;

   always @* begin
      state_d  = state_q;
      bitCnt_d = bitCnt_q;
      shift_d  = shift_q;
      case (state_q)
         ST_IDLE: begin
            if (bitTake) begin
               shift_d  = {30'h0, dataSync};
               bitCnt_d = 5'h01;
               state_d  = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (!portOpen || selRise) begin
               // Partial frame dropped when select is released
               bitCnt_d = 5'h00;
               state_d  = ST_IDLE;
            end else if (bitTake) begin
               shift_d  = {shift_q[29:0], dataSync};
               bitCnt_d = bitCnt_q + 5'h01;
               if (lastBit) begin
                  state_d = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            // Counter has wrapped; the 33rd clock starts a new frame
            bitCnt_d = 5'h00;
            if (!portOpen) begin
               state_d = ST_IDLE;
            end else if (bitTake) begin
               shift_d  = {30'h0, dataSync};
               bitCnt_d = 5'h01;
               state_d  = ST_SHIFT;
            end else begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d  = ST_IDLE;
            bitCnt_d = 5'h00;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         state_q  <= ST_IDLE;
         bitCnt_q <= 5'h00;
         shift_q  <= 31'h0;
      end else begin
         state_q  <= state_d;
         bitCnt_q <= bitCnt_d;
         shift_q  <= shift_d;
      end
   end

   // -------------------------------------------------------------------------
   // Write-only register file
   // -------------------------------------------------------------------------
   // No read path exists; values only leave as configuration outputs
   wire [15:0] cfgReg;
   wire [15:0] offReg;
   wire [15:0] fsReg;
   wire [15:0] fineReg;
   wire [15:0] crsReg;
   wire [15:0] tpReg;

   write_only_reg #(.ADDR(`SCP_ADDR_CONFIG), .RESET_VAL(`SCP_RST_CONFIG)) u_cfg (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .commit     (commitNow),
      .commitAddr (frameAddr),
      .commitData (frameData),
      .value_q    (cfgReg)
   );

   write_only_reg #(.ADDR(`SCP_ADDR_OFFSET), .RESET_VAL(`SCP_RST_OFFSET)) u_off (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .commit     (commitNow),
      .commitAddr (frameAddr),
      .commitData (frameData),
      .value_q    (offReg)
   );

   write_only_reg #(.ADDR(`SCP_ADDR_FULLSCALE), .RESET_VAL(`SCP_RST_FULLSCALE)) u_fs (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .commit     (commitNow),
      .commitAddr (frameAddr),
      .commitData (frameData),
      .value_q    (fsReg)
   );

   write_only_reg #(.ADDR(`SCP_ADDR_PHASE_FINE), .RESET_VAL(`SCP_RST_PHASE_FINE)) u_fine (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .commit     (commitNow),
      .commitAddr (frameAddr),
      .commitData (frameData),
      .value_q    (fineReg)
   );

   write_only_reg #(.ADDR(`SCP_ADDR_PHASE_CRS), .RESET_VAL(`SCP_RST_PHASE_CRS)) u_crs (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .commit     (commitNow),
      .commitAddr (frameAddr),
      .commitData (frameData),
      .value_q    (crsReg)
   );

   write_only_reg #(.ADDR(`SCP_ADDR_TEST_PAT), .RESET_VAL(`SCP_RST_TEST_PAT)) u_tp (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .commit     (commitNow),
      .commitAddr (frameAddr),
      .commitData (frameData),
      .value_q    (tpReg)
   );

   // -------------------------------------------------------------------------
   // Effective configuration
   // -------------------------------------------------------------------------
   // In normal mode registers are masked: reset defaults and pins take over
   always @(posedge clk_sys) begin
      if (srst) begin
         extendedMode           <= 1'b0;
         accessActive           <= 1'b0;
         commitPulse            <= 1'b0;
         headerError            <= 1'b0;
         commitAddr             <= 4'h0;
         diffResetInputSel      <= 1'b0;
         terminationTrimOff     <= 1'b0;
         dutyStabilizerOn       <= 1'b1;
         doubleRateClockPhase   <= 1'b0;
         singleRateSelect       <= 1'b0;
         outputSwingSelect      <= 1'b1;
         outputEdgeSelect       <= 1'b0;
         inputOffsetAdjust      <= `SCP_RST_OFFSET;
         fullScaleGainAdjust    <= `SCP_RST_FULLSCALE;
         sampleClockPhaseFine   <= `SCP_RST_PHASE_FINE;
         sampleClockPhaseCoarse <= `SCP_RST_PHASE_CRS;
         testPatternControl     <= `SCP_RST_TEST_PAT;
      end else begin
         extendedMode <= extNow;
         accessActive <= (state_q == ST_SHIFT);
         commitPulse  <= commitNow;
         headerError  <= badFrame;
         if (commitNow) begin
            commitAddr <= frameAddr;
         end
         if (extNow) begin
            diffResetInputSel      <= cfgReg[`SCP_CFG_DIFF_RST];
            terminationTrimOff     <= cfgReg[`SCP_CFG_TRIM_OFF];
            dutyStabilizerOn       <= cfgReg[`SCP_CFG_DUTY_STAB];
            doubleRateClockPhase   <= cfgReg[`SCP_CFG_DDR_PHASE] &
                                      ~cfgReg[`SCP_CFG_SINGLE_RATE];
            singleRateSelect       <= cfgReg[`SCP_CFG_SINGLE_RATE];
            outputSwingSelect      <= cfgReg[`SCP_CFG_SWING];
            outputEdgeSelect       <= cfgReg[`SCP_CFG_EDGE];
            inputOffsetAdjust      <= offReg;
            fullScaleGainAdjust    <= fsReg;
            sampleClockPhaseFine   <= fineReg;
            sampleClockPhaseCoarse <= crsReg;
            testPatternControl     <= tpReg;
         end else begin
            diffResetInputSel      <= 1'b0;
            terminationTrimOff     <= 1'b0;
            dutyStabilizerOn       <= 1'b1;
            doubleRateClockPhase   <= 1'b0;
            singleRateSelect       <= ratePinS;
            outputSwingSelect      <= swingPinS;
            outputEdgeSelect       <= edgePinS;
            inputOffsetAdjust      <= `SCP_RST_OFFSET;
            fullScaleGainAdjust    <= `SCP_RST_FULLSCALE;
            sampleClockPhaseFine   <= `SCP_RST_PHASE_FINE;
            sampleClockPhaseCoarse <= `SCP_RST_PHASE_CRS;
            testPatternControl     <= `SCP_RST_TEST_PAT;
         end
      end
   end

endmodule // serial_config_write_port

//--- logic/serial_config_defs.vh
// Constants for the serial configuration write port
// Operation
// - Frames are taken only in extended control mode; the port is ignored otherwise.
// - Data sampled on each rising serial clock edge; no minimum serial clock rate.
// - Each write is a 32-bit frame: header, address, value, MSB first.
// - Header is eleven zeros then a one, zero sent first.
// - Then a 4-bit address A3 first, then 16 data bits.
// - Next frame may start at the 33rd serial clock without releasing select.
// - All registers are write-only; nothing can be read back.
// - Decode 1h config, 2h offset, 3h full-scale, Dh/Eh phase, Fh test; rest reserved.
// - Register contents have no effect in normal control mode.
// - Config bit 14 picks clock reset input: 0 single-ended, 1 differential; resets 0.
// - Config bit 13 set skips termination trim, keeps output clock on; resets 0.
// - Config bit 12 enables duty-cycle stabilizer; resets 1.
// - Config bit 11 in double rate: 0 edge-aligned, 1 mid-cell half-speed clock; resets 0.
// - Config bit 10: 0 double rate, 1 single rate with edge from bit 8; resets 0.
// - Config bit 9: 1 standard 680 mV swing, 0 reduced 520 mV; resets 1.
// - Config bit 8 in single rate: 1 rising, 0 falling edge; write 0 in double rate.
// - Control mode comes from a dedicated pin, fixed during operation.
`ifndef SERIAL_CONFIG_DEFS_VH
`define SERIAL_CONFIG_DEFS_VH

// -----------------------------------------------------------------------------
// Frame layout
// -----------------------------------------------------------------------------
`define SCP_FRAME_BITS      32
`define SCP_HEADER_BITS     12
`define SCP_HEADER_VALUE    12'h001
`define SCP_HEADER_MSB      31
`define SCP_HEADER_LSB      20
`define SCP_ADDR_MSB        19
`define SCP_ADDR_LSB        16
`define SCP_DATA_MSB        15
`define SCP_DATA_LSB        0

// -----------------------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------------------
`define SCP_ADDR_CONFIG     4'h1
`define SCP_ADDR_OFFSET     4'h2
`define SCP_ADDR_FULLSCALE  4'h3
`define SCP_ADDR_PHASE_FINE 4'hd
`define SCP_ADDR_PHASE_CRS  4'he
`define SCP_ADDR_TEST_PAT   4'hf

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define SCP_RST_CONFIG      16'h92ff
`define SCP_RST_OFFSET      16'h007f
`define SCP_RST_FULLSCALE   16'h807f
`define SCP_RST_PHASE_FINE  16'h007f
`define SCP_RST_PHASE_CRS   16'h03ff
`define SCP_RST_TEST_PAT    16'hf7ff

// -----------------------------------------------------------------------------
// Configuration register fields
// -----------------------------------------------------------------------------
`define SCP_CFG_DIFF_RST    14
`define SCP_CFG_TRIM_OFF    13
`define SCP_CFG_DUTY_STAB   12
`define SCP_CFG_DDR_PHASE   11
`define SCP_CFG_SINGLE_RATE 10
`define SCP_CFG_SWING       9
`define SCP_CFG_EDGE        8

`endif

//--- logic/sync_two_stage.v
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module sync_two_stage #(
   parameter       WIDTH     = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input  wire             clk_sys,
   input  wire             srst,
   input  wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1_q;
   reg [WIDTH-1:0] stage2_q;

   // First stage feeds only the second stage
   always @(posedge clk_sys) begin
      if (srst) begin
         stage1_q <= RESET_VAL;
         stage2_q <= RESET_VAL;
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
      end
   end

   assign syncOut = stage2_q;

endmodule // sync_two_stage

//--- logic/write_only_reg.v
// One 16-bit write-only configuration register with address match
`timescale 1ns/1ps
module write_only_reg #(
   parameter [3:0]  ADDR      = 4'h0,
   parameter [15:0] RESET_VAL = 16'h0000
) (
   input  wire        clk_sys,
   input  wire        srst,
   input  wire        commit,
   input  wire [3:0]  commitAddr,
   input  wire [15:0] commitData,
   output reg  [15:0] value_q
);

   always @(posedge clk_sys) begin
      if (srst) begin
         value_q <= RESET_VAL;
      end else if (commit && (commitAddr == ADDR)) begin
         value_q <= commitData;
      end
   end

endmodule // write_only_reg

//--- verification/config_port_checker.sv
// Concurrent assertions for the serial configuration write port
`timescale 1ns/1ps
module config_port_checker #(
   parameter EXT_MODE_LEVEL = 1'b1
) (
   input wire        clk_sys,
   input wire        srst,
   input wire        rangeOrModeSelectPin,
   input wire        extendedMode,
   input wire        commitPulse,
   input wire        headerError,
   input wire [3:0]  commitAddr,
   input wire        diffResetInputSel,
   input wire        terminationTrimOff,
   input wire        dutyStabilizerOn,
   input wire        doubleRateClockPhase,
   input wire        singleRateSelect,
   input wire [15:0] inputOffsetAdjust,
   input wire [15:0] testPatternControl
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   sequence pinExt;
      (rangeOrModeSelectPin == EXT_MODE_LEVEL) [*4];
   endsequence
   sequence pinNorm;
      (rangeOrModeSelectPin != EXT_MODE_LEVEL) [*4];
   endsequence
   sequence stayNormal;
      !extendedMode [*2];
   endsequence

   mode_follow_a: assert property (pinExt |-> extendedMode)
      else $error("extended mode not taken from mode pin");
   mode_normal_a: assert property (pinNorm |-> !extendedMode)
      else $error("extended mode without mode pin");
   normal_cfg_a: assert property (stayNormal |->
      {diffResetInputSel, terminationTrimOff, dutyStabilizerOn, doubleRateClockPhase} == 4'b0010)
      else $error("config outputs not at defaults in normal mode");
   normal_regs_a: assert property (stayNormal |->
      inputOffsetAdjust == 16'h007f && testPatternControl == 16'hf7ff)
      else $error("register outputs not at defaults in normal mode");
   commit_once_a: assert property (commitPulse |=> !commitPulse)
      else $error("commit pulse longer than one cycle");
   commit_addr_a: assert property (commitPulse |-> extendedMode &&
      commitAddr inside {4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf})
      else $error("commit outside extended mode or to reserved address");
   pulse_excl_a: assert property (!(commitPulse && headerError))
      else $error("commit and header fault together");
   rate_gate_a: assert property (singleRateSelect |-> !doubleRateClockPhase)
      else $error("double rate phase active in single rate");
   offset_hold_a: assert property ($past(extendedMode, 2) && extendedMode &&
      $changed(inputOffsetAdjust) |-> $past(commitPulse) && commitAddr == 4'h2)
      else $error("offset output changed without its commit");
   config_hold_a: assert property ($past(extendedMode, 2) && extendedMode &&
      $changed(diffResetInputSel) |-> $past(commitPulse) && commitAddr == 4'h1)
      else $error("config output changed without its commit");
endmodule // config_port_checker

bind serial_config_write_port config_port_checker #(.EXT_MODE_LEVEL(EXT_MODE_LEVEL)) checker_i (
   .clk_sys, .srst, .rangeOrModeSelectPin, .extendedMode, .commitPulse, .headerError,
   .commitAddr, .diffResetInputSel, .terminationTrimOff, .dutyStabilizerOn,
   .doubleRateClockPhase, .singleRateSelect, .inputOffsetAdjust, .testPatternControl);

//--- verification/serial_host_model.sv
// Host controller model driving the three-wire serial configuration link
`timescale 1ns/1ps
module serial_host_model (
   output logic serialClock,
   output logic serialInputLine,
   output logic serialSelectN
);
   initial begin
      serialClock = 1'b0;
      serialInputLine = 1'b0;
      serialSelectN = 1'b1;
   end

   // No calibration runs beside this model, so a write never overlaps one
   // Shifts nBits MSB first, 160 ns per bit; clock idles low outside frames
   task automatic send(input logic [31:0] frame, input int nBits, input bit keepSel);
      serialSelectN = 1'b0;
      for (int i = 0; i < nBits; i++) begin
         serialInputLine = frame[31 - i];
         #80 serialClock = 1'b1;
         #80 serialClock = 1'b0;
      end
      #80;
      if (!keepSel) begin
         serialSelectN = 1'b1;
         serialInputLine = ~serialInputLine;
      end
   endtask
endmodule // serial_host_model

//--- verification/tb_serial_config_write_port.sv
// Self-checking testbench for the serial configuration write port
`timescale 1ns/1ps
`include "serial_config_defs.vh"
module tb_serial_config_write_port;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   localparam logic [15:0] RST_VALS [0:4] = '{`SCP_RST_OFFSET, `SCP_RST_FULLSCALE,
      `SCP_RST_PHASE_FINE, `SCP_RST_PHASE_CRS, `SCP_RST_TEST_PAT};
   logic        clk_sys   = 1'b0;
   logic        srst      = 1'b1;
   logic        modePin   = 1'b1;
   logic        edgePin   = 1'b0;
   logic        swingPin  = 1'b0;
   logic        ratePin   = 1'b0;
   logic [6:0]  expCfg    = 7'b0010010;
   logic [15:0] expR [0:4];
   wire         sclk, serial_input_line, selN, extMode, active, commitP, hdrErr;
   wire  [3:0]  cAddr;
   wire  [6:0]  cfg;
   wire  [15:0] regs [0:4];
   int          error_cnt   = 0;
   int          check_count = 0;
   int          commitCnt   = 0;
   int          hdrCnt      = 0;
   int          activeCnt   = 0;

   serial_config_write_port serial_config_write_port_i (
      .clk_sys(clk_sys), .srst(srst), .serialClock(sclk), .serialInputLine(serial_input_line),
      .serialSelectN(selN), .rangeOrModeSelectPin(modePin), .edgeSelectPin(edgePin),
      .swingSelectPin(swingPin), .singleRateOutput(ratePin), .extendedMode(extMode),
      .accessActive(active), .commitPulse(commitP), .headerError(hdrErr), .commitAddr(cAddr),
      .diffResetInputSel(cfg[6]), .terminationTrimOff(cfg[5]), .dutyStabilizerOn(cfg[4]),
      .doubleRateClockPhase(cfg[3]), .singleRateSelect(cfg[2]), .outputSwingSelect(cfg[1]),
      .outputEdgeSelect(cfg[0]), .inputOffsetAdjust(regs[0]), .fullScaleGainAdjust(regs[1]),
      .sampleClockPhaseFine(regs[2]), .sampleClockPhaseCoarse(regs[3]),
      .testPatternControl(regs[4]));
   serial_host_model serial_host_model_i (
      .serialClock(sclk), .serialInputLine(serial_input_line), .serialSelectN(selN));

   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (commitP === 1'b1) commitCnt++;
      if (hdrErr === 1'b1) hdrCnt++;
      if (active === 1'b1) activeCnt++;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chkAll;
      check("config bits", {9'h0, expCfg}, {9'h0, cfg});
      for (int i = 0; i < 5; i++)
         check("register", expR[i], regs[i]);
   endtask

   function automatic logic [31:0] frm(input logic [3:0] a, input logic [15:0] d);
      return {`SCP_HEADER_VALUE, a, d};
   endfunction

   // Sends a frame, then leaves room for the commit to land
   task automatic wr(input logic [31:0] f, input int n, input bit keep);
      serial_host_model_i.send(f, n, keep);
      repeat (8) @(negedge clk_sys);
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_config;
      logic [15:0] vals [0:2];
      logic [6:0]  exps [0:2];
      int          base;
      int          actBase;
      vals = '{16'hfeff, 16'h88ff, 16'h85ff};
      exps = '{7'b1110110, 7'b0001000, 7'b0000101};
      for (int i = 0; i < 3; i++) begin
         base = commitCnt;
         actBase = activeCnt;
         wr(frm(`SCP_ADDR_CONFIG, vals[i]), 32, 1'b0);
         expCfg = exps[i];
         chkAll();
         check("commits", 16'(base + 1), 16'(commitCnt));
         check("address", 16'h1, {12'h0, cAddr});
         check("active cycles", 16'd248, 16'(activeCnt - actBase));
         check("active", 16'h0, {15'h0, active});
      end
   endtask

   task automatic t_b2b;
      int base;
      base = commitCnt;
      wr(frm(`SCP_ADDR_OFFSET, 16'h5a7f), 32, 1'b1);
      wr(frm(`SCP_ADDR_FULLSCALE, 16'ha07f), 32, 1'b1);
      wr(frm(`SCP_ADDR_PHASE_FINE, 16'h3c7f), 32, 1'b1);
      wr(frm(`SCP_ADDR_PHASE_CRS, 16'hd3ff), 32, 1'b1);
      wr(frm(`SCP_ADDR_TEST_PAT, 16'hffff), 32, 1'b0);
      expR = '{16'h5a7f, 16'ha07f, 16'h3c7f, 16'hd3ff, 16'hffff};
      chkAll();
      check("commits", 16'(base + 5), 16'(commitCnt));
   endtask

   task automatic t_reserved;
      int base;
      base = commitCnt;
      for (int a = 0; a < 16; a++) begin
         if (!(a inside {1, 2, 3, 13, 14, 15}))
            wr(frm(4'(a), 16'h0000), 32, 1'b0);
      end
      chkAll();
      check("commits", 16'(base), 16'(commitCnt));
   endtask

   task automatic t_header;
      int base;
      base = commitCnt;
      wr({12'h002, `SCP_ADDR_OFFSET, 16'h007f}, 32, 1'b0);
      wr({12'h801, `SCP_ADDR_OFFSET, 16'h007f}, 32, 1'b0);
      chkAll();
      check("commits", 16'(base), 16'(commitCnt));
      check("header faults", 16'h2, 16'(hdrCnt));
   endtask

   task automatic t_abort;
      int base;
      base = commitCnt;
      wr(frm(`SCP_ADDR_OFFSET, 16'h117f), 20, 1'b0);
      wr(frm(`SCP_ADDR_OFFSET, 16'h227f), 32, 1'b0);
      expR[0] = 16'h227f;
      chkAll();
      check("commits", 16'(base + 1), 16'(commitCnt));
   endtask

   task automatic t_normal;
      int base;
      modePin = 1'b0;
      edgePin = 1'b1;
      ratePin = 1'b1;
      repeat (6) @(negedge clk_sys);
      base = commitCnt;
      wr(frm(`SCP_ADDR_CONFIG, 16'hfeff), 32, 1'b0);
      wr(frm(`SCP_ADDR_OFFSET, 16'h557f), 32, 1'b0);
      expCfg = 7'b0010101;
      expR = RST_VALS;
      chkAll();
      check("commits", 16'(base), 16'(commitCnt));
      check("mode", 16'h0, {15'h0, extMode});
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      expR = RST_VALS;
      repeat (3) @(negedge clk_sys);
      srst = 1'b0;
      repeat (6) @(negedge clk_sys);
      check("mode", 16'h1, {15'h0, extMode});
      chkAll();
      t_config();
      t_b2b();
      t_reserved();
      t_header();
      t_abort();
      t_normal();
      finish_test();
   end

   initial begin
      #500000;
      error_cnt++;
      finish_test();
   end
endmodule // tb_serial_config_write_port
